/* File: dv/in_ep_cfg_assertions.sv */
// Checker of the in endpoint answers, seen at the top ports
// Assumes one clock and traffic only while config is left alone
`timescale 1ns/1ps
module in_ep_cfg_chk
  import in_ep_pkg::*;
(
  input wire logic CLK_I, RESET_I, IN_REQ_I, IN_ACK_I, BVALID_O, IRQ_O, BUF_Y_O,
  input in_ep_pkg::answer_t ANSWER_O,
  input in_ep_pkg::data_pid_t PID_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Back-to-back tokens only, so config cannot move in between
  property p_flip; IN_REQ_I && IN_ACK_I ##1 IN_REQ_I && ANSWER_O == HS_DATA |=> PID_O != $past(PID_O); endproperty
  a_flip: assert property (p_flip) else $error("toggle kept after success");
  property p_keep; IN_REQ_I && !IN_ACK_I ##1 IN_REQ_I |=> PID_O == $past(PID_O); endproperty
  a_keep: assert property (p_keep) else $error("toggle moved without ack");
  property p_buf; IN_REQ_I && IN_ACK_I ##1 IN_REQ_I && BUF_Y_O && ANSWER_O == HS_DATA |=> !BUF_Y_O; endproperty
  a_buf: assert property (p_buf) else $error("buffer did not alternate");
  property p_stall; IN_REQ_I ##1 IN_REQ_I && ANSWER_O == HS_STALL |=> ANSWER_O == HS_STALL; endproperty
  a_stall: assert property (p_stall) else $error("stall answer dropped");
  property p_iso; IN_REQ_I ##1 IN_REQ_I && ANSWER_O == HS_ISO |=> ANSWER_O == HS_ISO && $stable(PID_O); endproperty
  a_iso: assert property (p_iso) else $error("iso answer changed");
  property p_off; IN_REQ_I ##1 IN_REQ_I && ANSWER_O == HS_NONE |=> ANSWER_O == HS_NONE; endproperty
  a_off: assert property (p_off) else $error("idle endpoint answered");
  property p_hold; !IN_REQ_I |=> ANSWER_O == HS_NONE; endproperty
  a_hold: assert property (p_hold) else $error("answer without token");
  property p_irq; $rose(IRQ_O) |-> $past(IN_REQ_I) || $rose(BVALID_O); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  c_data: cover property (IN_REQ_I && IN_ACK_I ##1 ANSWER_O == HS_DATA);
  c_stall: cover property (IN_REQ_I ##1 ANSWER_O == HS_STALL);
  c_irq: cover property ($rose(IRQ_O));
endmodule
bind in_ep_cfg in_ep_cfg_chk chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .IN_REQ_I(IN_REQ_I), .IN_ACK_I(IN_ACK_I),
  .BVALID_O(BVALID_O), .IRQ_O(IRQ_O), .BUF_Y_O(BUF_Y_O), .ANSWER_O(ANSWER_O), .PID_O(PID_O));

/* File: dv/test_in_ep_cfg.sv */
// Self-checking bench of the in endpoint config block
// Assumes AXI4-Lite master tasks and the host model
`timescale 1ns/1ps
module test_in_ep_cfg;
  import in_ep_pkg::*;
  logic clk, rst, awv, wv, bready, arv, rready, run, pend, tog, yb, e_pid, e_buf;
  logic awready, wready, bvalid, arready, rvalid, irq, buf_y, req, ack;
  logic [7:0] awaddr, araddr, cfg;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] rnd;
  logic [2:0] evt, msk;
  answer_t ans, e_ans;
  data_pid_t pid;
  int bad_count, num_checks;
  localparam logic [7:0] CORNER [6] = '{8'h80, 8'h93, 8'hB4, 8'hAC, 8'hC4, 8'h37};
  in_ep_cfg dut_u (.CLK_I(clk), .RESET_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awv), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .IN_REQ_I(req), .IN_ACK_I(ack),
    .ANSWER_O(ans), .PID_O(pid), .BUF_Y_O(buf_y), .IRQ_O(irq));
  usb_host_model host_u (.clk_i(clk), .run_i(run), .rnd_i(rnd), .req_o(req), .ack_o(ack));
  ////////////////////////////////////////////////////////////////
  function automatic answer_t exp_ans(input logic [7:0] c);
    if (!c[7]) return HS_NONE;
    if (c[3]) return HS_STALL;
    return c[6] ? HS_ISO : HS_DATA;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
    input logic [31:0] ed);
    int n;
    logic ta, tw, tr;
    n = 0;
    @(posedge clk);
    if (w) begin
      awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    end else begin
      araddr <= a; arv <= 1'b1; rready <= 1'b1;
    end
    while (n < 40) begin
      // Sampled mid-cycle, so equal to what the next edge sees
      @(negedge clk);
      ta = awv && awready || arv && arready;
      tw = wv && wready;
      tr = bready && bvalid || rready && rvalid;
      if (tr) chk("resp", er, w ? bresp : rresp);
      if (tr && !w) chk("rdata", ed, rdata);
      @(posedge clk);
      if (ta) begin awv <= 1'b0; arv <= 1'b0; end
      if (tw) wv <= 1'b0;
      if (tr) begin bready <= 1'b0; rready <= 1'b0; n = 99; end else n++;
    end
    chk("bus done", 32'd99, n);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  function automatic logic [15:0] lfsr(input logic [15:0] r);
    return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction
  always @(posedge clk) rnd <= lfsr(rnd);
  always @(negedge clk) if (!rst) begin
    if (pend) chk("answer", e_ans, ans);
    if (pend) chk("pid", e_pid, pid);
    if (pend) chk("buffer", e_buf, buf_y);
    pend = req;
    if (req) begin
      e_ans = exp_ans(cfg); e_pid = tog; e_buf = cfg[4] & yb;
      if (e_ans == HS_DATA && ack) begin tog = !tog; yb ^= cfg[4]; end
      if (cfg[2]) evt |= {e_ans == HS_ISO, e_ans == HS_STALL, e_ans == HS_DATA && ack};
    end
  end
  initial begin #160000; bad_count++; end_of_test; end
  initial begin
    rst = 1'b1; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; run = 0; awaddr = 0; araddr = 0; wdata = 0;
    rnd = 16'd57162; pend = 0; tog = 0; yb = 0; evt = 0; cfg = 0; bad_count = 0; num_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1, 8'h10, 32'h0000_0001, 2'h2, 0);
    bus(0, 8'h10, 0, 2'h2, 0);
    for (int i = 0; i < 16; i++) begin
      cfg = i < 6 ? CORNER[i] : rnd[7:0] & 8'hBF;
      msk = rnd[10:8];
      bus(1, 8'h00, cfg, 0, 0);
      tog = cfg[5];
      if (!cfg[4]) yb = 0;
      bus(0, 8'h00, 0, 0, {24'h0, cfg & 8'hFC});
      bus(1, 8'h08, msk, 0, 0);
      run <= 1'b1;
      repeat (24) @(posedge clk);
      run <= 1'b0;
      repeat (3) @(posedge clk);
      bus(0, 8'h04, 0, 0, evt);
      @(negedge clk);
      chk("irq", |(evt & msk), irq);
      bus(0, 8'h0C, 0, 0, {29'h0, cfg[4] & yb, tog, cfg[3]});
      bus(1, 8'h04, 32'h0000_0007, 0, 0);
      evt = 0;
      bus(0, 8'h04, 0, 0, 0);
      chk("irq clear", 32'h0000_0000, irq);
    end
    // Reset after the last round must bring config and interrupt status back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h00, 0, 0, 0);
    bus(0, 8'h04, 0, 0, 0);
    chk("irq reset", 32'h0000_0000, irq);
    end_of_test;
  end
endmodule

/* File: dv/usb_host_model.sv */
// Host model issuing in tokens, acking or timing out at random
// Assumes the bench gates it with run_i
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [15:0] rnd_i,
  output logic req_o,
  output logic ack_o
);
  initial begin
    req_o = 1'b0;
    ack_o = 1'b0;
  end
  always @(posedge clk_i) begin
    req_o <= run_i && rnd_i[1:0] != 2'b00;
    ack_o <= rnd_i[2];
  end
endmodule

/* File: rtl/ep_cfg_if.sv */
// Carrier between the bus slave side and the transaction logic
// Assumes one clock domain
`timescale 1ns/1ps
interface ep_cfg_if;
  logic [7:0] cfg;
  logic flip_toggle;
  modport owner(output cfg, input flip_toggle);
  modport user(input cfg, output flip_toggle);
endinterface

/* File: rtl/in_ep_cfg.sv */
// Operation
// - Type bit set selects isochronous endpoint
// - Toggle flips only after successful data
// - Toggle zero sends DATA0, one DATA1
// - Two-buffer bit alternates X and Y
// - Stall bit answers every transaction STALL
// - Low two bits reserved, no effect
// - Active bit enables endpoint participation
//
// In endpoint configuration byte with AXI4-Lite slave and interrupt
// Assumes the serial engine shares CLK_I and holds IN_REQ_I one cycle per token
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "in_ep_map.svh"
module in_ep_cfg
  import in_ep_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Serial engine side
  input wire logic IN_REQ_I,
  input wire logic IN_ACK_I,
  output in_ep_pkg::answer_t ANSWER_O,
  output in_ep_pkg::data_pid_t PID_O,
  output logic BUF_Y_O,
  // Interrupt
  output logic IRQ_O
);
  import in_ep_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Register decode helpers; word_addr and reg_mapped shared by both channels, read_word by the read channel
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    logic hit;
    case (a)
      `OFF_CFG, `OFF_IRQ_STATUS, `OFF_IRQ_MASK, `OFF_EP_STATUS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Unmapped offsets read as zero
  function automatic logic [31:0] read_word(input logic [7:0] a, input logic [7:0] c,
    input logic [2:0] s, input logic [2:0] m, input logic [31:0] e);
    logic [31:0] d;
    case (a)
      `OFF_CFG: begin
        d = {24'h0, c};
      end
      `OFF_IRQ_STATUS: begin
        d = {29'h0, s};
      end
      `OFF_IRQ_MASK: begin
        d = {29'h0, m};
      end
      `OFF_EP_STATUS: begin
        d = e;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  ep_cfg_if cif();
  logic [7:0] cfg_ff;
  logic [2:0] irq_stat_ff, irq_mask_ff;
  logic [7:0] aw_ff;
  logic aw_ok_ff, w_ok_ff;
  logic [31:0] w_ff;
  logic [3:0] ws_ff;
  answer_t xans;
  data_pid_t xpid;
  logic xbuf, xdone;

  ////////////////////////////////////////////////////////////////////
  // Transaction logic
  in_ep_xact u_xact (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .cfg_if(cif.user),
    .req_i(IN_REQ_I),
    .ack_i(IN_ACK_I),
    .answer_o(xans),
    .pid_o(xpid),
    .buf_y_o(xbuf),
    .done_o(xdone)
  );
  assign cif.cfg = cfg_ff;

  ////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  wire aw_take = AWVALID_I & AWREADY_O;
  wire w_take = WVALID_I & WREADY_O;
  wire b_take = BVALID_O & BREADY_I;
  wire do_wr = aw_ok_ff & w_ok_ff & ~BVALID_O;
  wire byte0_wr = do_wr & ws_ff[0];
  wire wr_cfg = byte0_wr & (aw_ff == `OFF_CFG);
  wire wr_stat = byte0_wr & (aw_ff == `OFF_IRQ_STATUS);
  wire wr_mask = byte0_wr & (aw_ff == `OFF_IRQ_MASK);
  wire wr_known = reg_mapped(aw_ff);
  // Halves held until the write is done; ready returns when the response is taken; one write in flight
  wire nxt_aw_ok = ~do_wr & (aw_ok_ff | aw_take);
  wire nxt_w_ok = ~do_wr & (w_ok_ff | w_take);
  wire nxt_awready = b_take | (AWREADY_O & ~aw_take);
  wire nxt_wready = b_take | (WREADY_O & ~w_take);
  wire nxt_bvalid = do_wr | (BVALID_O & ~BREADY_I);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
    end else begin
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aw_ff <= 8'h00;
    end else if (aw_take) begin
      aw_ff <= word_addr(AWADDR_I);
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      w_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
    end else if (w_take) begin
      w_ff <= WDATA_I;
      ws_ff <= WSTRB_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
    end else begin
      AWREADY_O <= nxt_awready;
      WREADY_O <= nxt_wready;
    end
  end

  // Unmapped offsets still complete, with SLVERR
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= 2'h0;
    end else begin
      BVALID_O <= nxt_bvalid;
      if (do_wr) begin
        BRESP_O <= wr_known ? 2'h0 : 2'h2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration byte; toggle is owned by the transaction logic
  // Firmware write of toggle wins only when no flip lands that cycle
  wire [7:0] wcfg = w_ff[7:0] & `CFG_WMASK;
  wire nxt_toggle = cif.flip_toggle ? ~cfg_ff[`BIT_TOGGLE] :
    (wr_cfg ? wcfg[`BIT_TOGGLE] : cfg_ff[`BIT_TOGGLE]);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg_ff <= `CFG_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= wcfg;
      end
      cfg_ff[`BIT_TOGGLE] <= nxt_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky events; set wins over write-one clear
  wire [2:0] evt;
  assign evt[`EVT_DONE] = xdone & cfg_ff[`BIT_IRQ_EN];
  assign evt[`EVT_STALL] = (xans == HS_STALL) & cfg_ff[`BIT_IRQ_EN];
  assign evt[`EVT_ISO] = (xans == HS_ISO) & cfg_ff[`BIT_IRQ_EN];
  wire [2:0] clr = wr_stat ? w_ff[2:0] : 3'h0;
  wire [2:0] nxt_stat = (irq_stat_ff & ~clr) | evt;
  wire [2:0] nxt_mask = wr_mask ? w_ff[2:0] : irq_mask_ff;
  wire nxt_irq = |(nxt_stat & nxt_mask);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_stat_ff <= `IRQ_RESET;
    end else begin
      irq_stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_mask_ff <= `IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_ff <= w_ff[2:0];
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read channel
  wire [7:0] ra = word_addr(ARADDR_I);
  wire [31:0] ep_stat = {29'h0, xbuf, cfg_ff[`BIT_TOGGLE], cfg_ff[`BIT_STALL]};
  wire r_known = reg_mapped(ra);
  wire [31:0] rsel = read_word(ra, cfg_ff, irq_stat_ff, irq_mask_ff, ep_stat);
  wire ar_take = ARVALID_I & ARREADY_O;
  wire r_take = RVALID_O & RREADY_I;

  // One read in flight; data frozen until the master takes it
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
    end else if (ar_take) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
    end else if (r_take) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= 2'h0;
    end else if (ar_take) begin
      RDATA_O <= rsel;
      RRESP_O <= r_known ? 2'h0 : 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link answers registered; PID reflects toggle at token time
  // Answer falls back to none in the cycle after any cycle without a token
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ANSWER_O <= HS_NONE;
    end else begin
      ANSWER_O <= xans;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PID_O <= PID_DATA0;
    end else begin
      PID_O <= xpid;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BUF_Y_O <= 1'b0;
    end else begin
      BUF_Y_O <= xbuf;
    end
  end
endmodule

/* File: rtl/in_ep_map.svh */
// Register offsets, field positions, reset values and event bits for the in endpoint block
// Assumes inclusion by bare name from the design files
`ifndef IN_EP_MAP_SVH
`define IN_EP_MAP_SVH

`define OFF_CFG 8'h00
`define OFF_IRQ_STATUS 8'h04
`define OFF_IRQ_MASK 8'h08
`define OFF_EP_STATUS 8'h0C

`define BIT_ACTIVE 7
`define BIT_ISO 6
`define BIT_TOGGLE 5
`define BIT_TWO_BUF 4
`define BIT_STALL 3
`define BIT_IRQ_EN 2

`define CFG_RESET 8'h00
`define CFG_WMASK 8'hFC
`define IRQ_RESET 3'h0

`define EVT_DONE 0
`define EVT_STALL 1
`define EVT_ISO 2

`endif

/* File: rtl/in_ep_pkg.sv */
// Types shared by the in endpoint block
// Assumes no other package
package in_ep_pkg;
  typedef enum logic [1:0] {HS_NONE, HS_DATA, HS_STALL, HS_ISO} answer_t;
  typedef enum logic {PID_DATA0, PID_DATA1} data_pid_t;
endpackage

/* File: rtl/in_ep_xact.sv */
// Transaction answer logic of one in endpoint
// Assumes requests from the serial engine on the same clock
`timescale 1ns/1ps
`include "in_ep_map.svh"
module in_ep_xact
  import in_ep_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  ep_cfg_if.user cfg_if,
  input wire logic req_i,
  input wire logic ack_i,
  output in_ep_pkg::answer_t answer_o,
  output in_ep_pkg::data_pid_t pid_o,
  output logic buf_y_o,
  output logic done_o
);
  logic buf_y_ff;
  wire active = cfg_if.cfg[`BIT_ACTIVE];
  wire stall = cfg_if.cfg[`BIT_STALL];
  wire iso = cfg_if.cfg[`BIT_ISO];
  wire two_buf = cfg_if.cfg[`BIT_TWO_BUF];
  wire good = req_i & ack_i & active & ~stall & ~iso;

  assign cfg_if.flip_toggle = good;
  assign done_o = good;

  // Stall beats data; disabled endpoint stays silent
  always_comb begin
    answer_o = HS_NONE;
    if (req_i & active) begin
      if (stall) answer_o = HS_STALL;
      else if (iso) answer_o = HS_ISO;
      else answer_o = HS_DATA;
    end
  end

  assign pid_o = cfg_if.cfg[`BIT_TOGGLE] ? PID_DATA1 : PID_DATA0;
  assign buf_y_o = two_buf & buf_y_ff;

  // Alternate X and Y only after a delivered packet
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) buf_y_ff <= 1'b0;
    else if (!two_buf) buf_y_ff <= 1'b0;
    else if (good) buf_y_ff <= ~buf_y_ff;
  end
endmodule
